// ### spc_pkg.sv
// Package: constants, types and register map of the serial port config block
package spc_pkg;

	// ------------------------------------------------------------------
	// Clock and timing
	// ------------------------------------------------------------------
	localparam int CLK_HZ = 20_000_000; // System clock rate in Hz
	localparam int OVERSAMPLE = 16; // Baud ticks per bit time

	// ------------------------------------------------------------------
	// Register map (byte addresses, one aligned word each)
	// ------------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_FIRST_SERIAL_PORT = 8'h00; // first_port_param_reg
	localparam logic [7:0] OFS_SECOND_SERIAL_PORT = 8'h04; // second_port_param_reg
	localparam logic [7:0] OFS_PORT2N = 8'h08; // third_port_normal_param_reg
	localparam logic [7:0] OFS_PORT2L = 8'h0c; // third_port_link_param_reg
	localparam logic [7:0] OFS_CTRL = 8'h10; // Link control bits
	localparam logic [7:0] OFS_STAT_CFG = 8'h14; // Effective parameters
	localparam logic [7:0] OFS_STAT_MODE = 8'h18; // Interfaces and switch

	// ------------------------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] KEY_BYTE = 8'h55;
	localparam logic [15:0] FIRST_SERIAL_PORT_RST = 16'h0000;
	localparam logic [15:0] SECOND_SERIAL_PORT_RST = 16'h0000;
	localparam logic [15:0] PORT2N_RST = 16'h0000;
	localparam logic [15:0] PORT2L_RST = 16'h5565;
	localparam logic [15:0] LINK_FIX_VAL = 16'h5565;
	localparam int CTRL_LINK_RUN_BIT = 0; // fast_link_instruction running
	localparam int CTRL_HS_LINK_BIT = 1; // third_port_link_op mode
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [7:0] P0_CODE_19200 = 8'h00;
	localparam logic [7:0] P0_CODE_9600 = 8'h01;
	localparam logic [7:0] P0_CODE_38400 = 8'h02;
	localparam logic [1:0] SW_FIRST_SERIAL_PORT_DEF = 2'h3; // Both switch bits on
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [3:0] {
		SPC_B4800 = 4'h0, SPC_B9600 = 4'h1, SPC_B19200 = 4'h2,
		SPC_B38400 = 4'h3, SPC_B57600 = 4'h4, SPC_B76800 = 4'h5,
		SPC_B153600 = 4'h6, SPC_B307200 = 4'h7, SPC_B614400 = 4'h8
	} spc_baud_e;

	typedef enum logic [1:0] {
		SPC_PAR_NONE = 2'h0, SPC_PAR_EVEN = 2'h1, SPC_PAR_ODD = 2'h2
	} spc_par_e;

	typedef enum logic [1:0] {
		SPC_IF_STD = 2'h0, SPC_IF_MODEM = 2'h1, SPC_IF_PROG = 2'h2
	} spc_iface_e;

	// Same bit layout as a parameter low byte
	typedef struct packed {
		spc_baud_e baud; // [7:4]
		logic two_stop; // [3]
		logic eight_bits; // [2]
		spc_par_e parity; // [1:0]
	} spc_cfg_s;

	localparam spc_cfg_s DEFAULT_CFG = '{baud: SPC_B9600, two_stop: 1'b0,
		eight_bits: 1'b0, parity: SPC_PAR_EVEN};
	localparam spc_baud_e P01_MAX_BAUD = SPC_B38400;
	localparam spc_baud_e P2_MAX_BAUD = SPC_B614400;
	localparam spc_baud_e LINK_MIN_BAUD = SPC_B38400;

	// Bit rate of a baud code
	function automatic int baud_hz(input spc_baud_e b);
		unique case (b)
			SPC_B4800: baud_hz = 4800;
			SPC_B9600: baud_hz = 9600;
			SPC_B19200: baud_hz = 19200;
			SPC_B38400: baud_hz = 38400;
			SPC_B57600: baud_hz = 57600;
			SPC_B76800: baud_hz = 76800;
			SPC_B153600: baud_hz = 153600;
			SPC_B307200: baud_hz = 307200;
			default: baud_hz = 614400;
		endcase
	endfunction : baud_hz

endpackage : spc_pkg

// ### spc_param_decode.sv
// Decoder from a keyed parameter register to an effective port setting
module spc_param_decode #(
	parameter int PORT_KIND = 0 // 0 first, 1 second, 2 third port
) (
	input wire logic [15:0] raw, // Parameter register contents
	input wire logic force_default, // Switch demands defaults
	output spc_pkg::spc_cfg_s cfg // Effective setting
);

	// ------------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------------
	if (PORT_KIND < 0 || PORT_KIND > 2) begin : g_bad_kind
		$error("spc_param_decode: PORT_KIND must be 0, 1 or 2");
	end

	spc_pkg::spc_cfg_s low;
	spc_pkg::spc_baud_e max_baud;

	assign low = spc_pkg::spc_cfg_s'(raw[7:0]);
	assign max_baud = (PORT_KIND == 2) ? spc_pkg::P2_MAX_BAUD :
		spc_pkg::P01_MAX_BAUD;

	// ------------------------------------------------------------------
	// Key check and per-port decoding
	// ------------------------------------------------------------------
	always_comb begin
		cfg = spc_pkg::DEFAULT_CFG;
		if (force_default || raw[15:8] != spc_pkg::KEY_BYTE) begin
			cfg = spc_pkg::DEFAULT_CFG;
		end else if (PORT_KIND == 0) begin
			// Only the rate moves; unknown codes keep the default
			unique case (raw[7:0])
				spc_pkg::P0_CODE_19200: cfg.baud = spc_pkg::SPC_B19200;
				spc_pkg::P0_CODE_9600: cfg.baud = spc_pkg::SPC_B9600;
				spc_pkg::P0_CODE_38400: cfg.baud = spc_pkg::SPC_B38400;
				default: cfg.baud = spc_pkg::SPC_B9600;
			endcase
		end else if (low.baud <= max_baud &&
			low.parity != 2'h3) begin
			// Rates above the port ceiling are refused
			cfg = low;
		end
	end

endmodule : spc_param_decode

// ### spc_serial_cfg.sv
// Top: serial port parameter registers, AXI4-Lite slave and baud ticks
// Function
// - Defaults 9600 baud, 7 bits, even, 1 stop
// - First port reg resets zero, key gates
// - First port low byte picks only rate
// - Second port reg resets zero, key gates
// - Third port: normal or link register
// - Third port normal reg needs key byte
// - Invalid link register overwritten with 0x5565
// - 0x5565 means 153600, 8, even, 1
// - Link instruction running makes third port programmed
// - Switch selects second port interface
// - Switch sampled once after each reset release only
// - Standard interface answers protocol frames only
// - Third port reaches 614.4k, others 38.4k
//
// Added by the designer: register access over AXI4-Lite and the register addresses.
module spc_serial_cfg #(
	parameter int CLK_HZ = spc_pkg::CLK_HZ // System clock in Hz
) (
	input wire logic clk_sys, // System clock
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic [1:0] iface_sel_sw, // interface_select_switch pins
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [7:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	// Port side
	output spc_pkg::spc_cfg_s [2:0] port_cfg, // Effective settings
	output spc_pkg::spc_iface_e [2:0] port_iface, // Software interface
	output logic [2:0] std_proto_en, // Frame driver owns the port
	output logic [2:0] baud_tick // Oversample enable pulses
);

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	if (CLK_HZ < spc_pkg::OVERSAMPLE * 614400) begin : g_bad_clk
		$error("spc_serial_cfg: clock too slow for the fastest rate");
	end
	if (CLK_HZ / (spc_pkg::OVERSAMPLE * 4800) > 65535) begin : g_big_clk
		$error("spc_serial_cfg: divider counter too narrow");
	end

	// Cycles per oversample tick for a rate, never below one
	function automatic logic [15:0] div_of(input spc_pkg::spc_baud_e b);
		int d;
		d = CLK_HZ / (spc_pkg::OVERSAMPLE * spc_pkg::baud_hz(b));
		if (d < 1) begin
			d = 1;
		end
		div_of = d[15:0];
	endfunction : div_of

	// Merge one write into a 16-bit register through the low two lanes
	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = data[7:0];
		end
		if (strb[1]) begin
			r[15:8] = data[15:8];
		end
		merge16 = r;
	endfunction : merge16

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [15:0] p0; // first_port_param_reg
		logic [15:0] p1; // second_port_param_reg
		logic [15:0] p2n; // third_port_normal_param_reg
		logic [15:0] p2l; // third_port_link_param_reg
		logic [1:0] ctrl; // Link run and link mode
		logic [1:0] sw_meta; // Switch synchroniser, first stage
		logic [1:0] sw_sync; // Switch synchroniser, second stage
		logic sw_taken; // Switch already captured
		logic [1:0] sw_val; // Captured switch position
		logic aw_got; // Write address held
		logic w_got; // Write data held
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		spc_pkg::spc_cfg_s [2:0] cfg; // Registered effective settings
		logic [2:0][15:0] cnt; // Tick dividers
		logic [2:0] tick;
	} spc_state_s;

	spc_state_s s_q;
	spc_state_s s_d;
	spc_pkg::spc_cfg_s [2:0] dec_cfg;
	logic [2:0][15:0] dec_raw;
	logic [2:0] dec_force;
	spc_pkg::spc_iface_e [2:0] iface;
	logic link_bad;
	logic hs_link;

	// ------------------------------------------------------------------
	// Parameter decoders
	// ------------------------------------------------------------------
	assign hs_link = s_q.ctrl[spc_pkg::CTRL_HS_LINK_BIT];
	// Third port follows the register of its current mode
	assign dec_raw[0] = s_q.p0;
	assign dec_raw[1] = s_q.p1;
	assign dec_raw[2] = hs_link ? s_q.p2l : s_q.p2n;
	// Both switch bits on pin the first port to defaults
	assign dec_force[0] = s_q.sw_taken &&
		s_q.sw_val == spc_pkg::SW_FIRST_SERIAL_PORT_DEF;
	assign dec_force[1] = 1'b0;
	assign dec_force[2] = 1'b0;

	for (genvar i = 0; i < 3; i++) begin : g_dec
		spc_param_decode #(
			.PORT_KIND(i)
		) u_dec (
			.raw(dec_raw[i]),
			.force_default(dec_force[i]),
			.cfg(dec_cfg[i])
		);
	end

	// ------------------------------------------------------------------
	// Interface selection
	// ------------------------------------------------------------------
	always_comb begin
		iface[0] = spc_pkg::SPC_IF_STD;
		unique case (s_q.sw_val)
			2'h1: iface[1] = spc_pkg::SPC_IF_MODEM;
			2'h2: iface[1] = spc_pkg::SPC_IF_PROG;
			default: iface[1] = spc_pkg::SPC_IF_STD;
		endcase
		if (s_q.ctrl[spc_pkg::CTRL_LINK_RUN_BIT]) begin
			iface[2] = spc_pkg::SPC_IF_PROG;
		end else begin
			iface[2] = spc_pkg::SPC_IF_STD;
		end
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		spc_pkg::spc_cfg_s lnk;
		lnk = spc_pkg::spc_cfg_s'(8'h00);
		link_bad = 1'b0;
		s_d = s_q;
		// Switch pins cross into the clock domain; runs even in reset
		s_d.sw_meta = iface_sel_sw;
		s_d.sw_sync = s_q.sw_meta;

		// Capture the switch once; later movement is ignored
		if (!s_q.sw_taken) begin
			s_d.sw_taken = 1'b1;
			s_d.sw_val = s_q.sw_sync;
			if (s_q.sw_sync == spc_pkg::SW_FIRST_SERIAL_PORT_DEF) begin
				s_d.p0 = spc_pkg::FIRST_SERIAL_PORT_RST;
			end
		end

		// Write channel: address and data taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_d.w_got = 1'b1;
			s_d.wdata = s_axi_wdata;
			s_d.wstrb = s_axi_wstrb;
		end
		if (s_q.aw_got && s_q.w_got) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = spc_pkg::AXI_OKAY;
			unique case (s_q.awaddr)
				spc_pkg::OFS_FIRST_SERIAL_PORT:
					s_d.p0 = merge16(s_q.p0, s_q.wdata, s_q.wstrb);
				spc_pkg::OFS_SECOND_SERIAL_PORT:
					s_d.p1 = merge16(s_q.p1, s_q.wdata, s_q.wstrb);
				spc_pkg::OFS_PORT2N:
					s_d.p2n = merge16(s_q.p2n, s_q.wdata, s_q.wstrb);
				spc_pkg::OFS_PORT2L:
					s_d.p2l = merge16(s_q.p2l, s_q.wdata, s_q.wstrb);
				spc_pkg::OFS_CTRL: begin
					if (s_q.wstrb[0]) begin
						s_d.ctrl = s_q.wdata[1:0];
					end
				end
				// Status words are read only; writes are accepted
				spc_pkg::OFS_STAT_CFG, spc_pkg::OFS_STAT_MODE: begin
				end
				default: s_d.bresp = spc_pkg::AXI_SLVERR;
			endcase
		end
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end

		// Link register is repaired in the same cycle whenever it is bad with link mode on, so a
		// bad software write is never seen by the port
		lnk = spc_pkg::spc_cfg_s'(s_d.p2l[7:0]);
		link_bad = s_d.p2l[15:8] != spc_pkg::KEY_BYTE || !lnk.eight_bits ||
			lnk.baud < spc_pkg::LINK_MIN_BAUD ||
			lnk.baud > spc_pkg::P2_MAX_BAUD;
		if (s_d.ctrl[spc_pkg::CTRL_HS_LINK_BIT] && link_bad) begin
			s_d.p2l = spc_pkg::LINK_FIX_VAL;
		end

		// Read channel: one cycle from address to data
		if (s_axi_arvalid && s_axi_arready) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = spc_pkg::AXI_OKAY;
			s_d.rdata = 32'h0000_0000;
			unique case (s_axi_araddr)
				spc_pkg::OFS_FIRST_SERIAL_PORT: s_d.rdata[15:0] = s_q.p0;
				spc_pkg::OFS_SECOND_SERIAL_PORT: s_d.rdata[15:0] = s_q.p1;
				spc_pkg::OFS_PORT2N: s_d.rdata[15:0] = s_q.p2n;
				spc_pkg::OFS_PORT2L: s_d.rdata[15:0] = s_q.p2l;
				spc_pkg::OFS_CTRL: s_d.rdata[1:0] = s_q.ctrl;
				spc_pkg::OFS_STAT_CFG:
					s_d.rdata[23:0] = {s_q.cfg[2], s_q.cfg[1], s_q.cfg[0]};
				spc_pkg::OFS_STAT_MODE:
					s_d.rdata[8:0] = {s_q.sw_taken, s_q.sw_val,
						iface[2], iface[1], iface[0]};
				default: s_d.rresp = spc_pkg::AXI_SLVERR;
			endcase
		end else if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end

		// Settings registered, then divided into oversample ticks
		for (int i = 0; i < 3; i++) begin
			s_d.cfg[i] = dec_cfg[i];
			if (s_q.cnt[i] >= div_of(s_q.cfg[i].baud) - 16'h0001) begin
				s_d.cnt[i] = 16'h0000;
				s_d.tick[i] = 1'b1;
			end else begin
				s_d.cnt[i] = s_q.cnt[i] + 16'h0001;
				s_d.tick[i] = 1'b0;
			end
		end

		// Synchronous reset of all control state
		if (!reset_n) begin
			s_d.p0 = spc_pkg::FIRST_SERIAL_PORT_RST;
			s_d.p1 = spc_pkg::SECOND_SERIAL_PORT_RST;
			s_d.p2n = spc_pkg::PORT2N_RST;
			s_d.p2l = spc_pkg::PORT2L_RST;
			s_d.ctrl = spc_pkg::CTRL_RST;
			s_d.sw_taken = 1'b0;
			s_d.sw_val = 2'h0;
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.awaddr = 8'h00;
			s_d.wdata = 32'h0000_0000;
			s_d.wstrb = 4'h0;
			s_d.bvalid = 1'b0;
			s_d.bresp = spc_pkg::AXI_OKAY;
			s_d.rvalid = 1'b0;
			s_d.rdata = 32'h0000_0000;
			s_d.rresp = spc_pkg::AXI_OKAY;
			s_d.cfg = {3{spc_pkg::DEFAULT_CFG}};
			s_d.cnt = '0;
			s_d.tick = 3'h0;
		end
	end

	// Single register stage for the whole state
	always_ff @(posedge clk_sys) begin
		s_q <= s_d;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// One write and one read in flight; ready drops while answering
	assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
	assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = s_q.rdata;
	assign s_axi_rresp = s_q.rresp;
	assign port_cfg = s_q.cfg;
	assign port_iface = iface;
	assign baud_tick = s_q.tick;

	// Frame driver owns only ports left on the standard interface
	for (genvar i = 0; i < 3; i++) begin : g_std
		assign std_proto_en[i] = iface[i] == spc_pkg::SPC_IF_STD;
	end

endmodule : spc_serial_cfg

// ### spc_serial_cfg_checker.sv
// Checker: bus handshakes and effective setting relations of the block
module spc_serial_cfg_checker (
	input wire logic clk_sys, // System clock
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic s_axi_awvalid, // Write address valid
	input wire logic s_axi_awready, // Write address ready
	input wire logic s_axi_wvalid, // Write data valid
	input wire logic s_axi_wready, // Write data ready
	input wire logic [1:0] s_axi_bresp, // Write response
	input wire logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic s_axi_arvalid, // Read address valid
	input wire logic s_axi_arready, // Read address ready
	input wire logic [31:0] s_axi_rdata, // Read data
	input wire logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire spc_pkg::spc_cfg_s [2:0] port_cfg, // Effective settings
	input wire spc_pkg::spc_iface_e [2:0] port_iface, // Interfaces
	input wire logic [2:0] std_proto_en, // Frame driver owns port
	input wire logic [2:0] baud_tick // Oversample pulses
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	// Both halves of a write taken at one edge
	sequence wr_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Read address taken
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence

	// ------------------------------------------------------------------
	// Bus handshakes
	// ------------------------------------------------------------------
	// Halves are latched first, so the answer stands two edges later
	wr_answer_a: assert property (wr_both |-> ##2 s_axi_bvalid)
		else $error("write response late");
	wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
	aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready
		&& !s_axi_wready) else $error("write taken while answering");
	rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
		else $error("read data late");
	rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
	ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answering");

	// ------------------------------------------------------------------
	// Effective settings
	// ------------------------------------------------------------------
	// Reset is checked here too, so this one is never disabled
	cfg_default_a: assert property (disable iff (1'b0)
		!reset_n |=> port_cfg == {3{spc_pkg::DEFAULT_CFG}})
		else $error("reset setting not default");
	first_serial_port_fixed_a: assert property (!port_cfg[0].eight_bits
		&& !port_cfg[0].two_stop && port_cfg[0].parity == spc_pkg::SPC_PAR_EVEN)
		else $error("first port frame not 7E1");
	first_serial_port_rate_a: assert property (port_cfg[0].baud inside
		{spc_pkg::SPC_B9600, spc_pkg::SPC_B19200, spc_pkg::SPC_B38400})
		else $error("first port rate illegal");
	std_en_a: assert property (std_proto_en == {
		port_iface[2] == spc_pkg::SPC_IF_STD, port_iface[1] == spc_pkg::SPC_IF_STD,
		port_iface[0] == spc_pkg::SPC_IF_STD}) else $error("frame owner wrong");
	// Capture happens at the first edge after release, so skip two edges
	iface_steady_a: assert property (reset_n && $past(reset_n, 2)
		|-> $stable(port_iface[1])) else $error("switch change taken late");
	tick_single_a: assert property (baud_tick[0] |=> !baud_tick[0])
		else $error("first port tick too wide");
endmodule : spc_serial_cfg_checker

bind spc_serial_cfg spc_serial_cfg_checker spc_serial_cfg_checker_inst (
	.clk_sys(clk_sys), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .port_cfg(port_cfg), .port_iface(port_iface),
	.std_proto_en(std_proto_en), .baud_tick(baud_tick));

// ### spc_peer_model.sv
// Far-side receiver model: measures oversample tick spacing of each port
module spc_peer_model (
	input wire logic clk_sys, // System clock
	input wire logic [2:0] baud_tick, // Oversample pulses
	output logic [15:0] gap [3] // Cycles between last two pulses
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] cnt [3] = '{16'h0, 16'h0, 16'h0};

	// The peer samples at its own rate, so only spacing matters here
	always @(posedge clk_sys) begin
		for (int i = 0; i < 3; i++) begin
			if (baud_tick[i]) begin
				gap[i] <= cnt[i] + 16'h1;
				cnt[i] <= 16'h0;
			end else begin
				cnt[i] <= cnt[i] + 16'h1;
			end
		end
	end
endmodule : spc_peer_model

// ### testbench.sv
// Testbench: register bus stimulus and reference model of the block
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic reset_n = 1'b0;
	logic [1:0] sw = 2'h0;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, resp;
	logic [31:0] rdata, rd;
	spc_pkg::spc_cfg_s [2:0] port_cfg;
	spc_pkg::spc_iface_e [2:0] port_iface;
	logic [2:0] std_en, tick;
	logic [15:0] gap [3];
	logic [7:0] offs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
	int rst [5] = '{32'h0, 32'h0, 32'h0, 32'h5565, 32'h0};
	int lk [5] = '{32'h5561, 32'h5525, 32'h1285, 32'h5536, 32'h5585};
	int fail_count = 0, total_checks = 0, seed = 32'h8d7e;
	int v, e, pn;

	always #25 clk_sys = ~clk_sys;

	spc_serial_cfg spc_serial_cfg_inst (.clk_sys(clk_sys), .reset_n(reset_n),
		.iface_sel_sw(sw), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.port_cfg(port_cfg), .port_iface(port_iface), .std_proto_en(std_en),
		.baud_tick(tick));
	spc_peer_model spc_peer_model_inst (.clk_sys(clk_sys), .baud_tick(tick),
		.gap(gap));

	// ------------------------------------------------------------------
	// Reference model of the effective setting byte
	// ------------------------------------------------------------------
	function automatic int m_cfg(input int p, input int raw);
		int lo;
		lo = raw & 32'hff;
		if ((raw >> 8) != 32'h55) return 32'h11;
		if (p == 0) return (lo == 0) ? 32'h21 : (lo == 2) ? 32'h31 : 32'h11;
		if ((lo >> 4) <= (p == 1 ? 3 : 8) && (lo & 3) != 3) return lo;
		return 32'h11;
	endfunction : m_cfg

	// Link register after the automatic repair
	function automatic int m_fix(input int raw);
		int bd;
		bd = (raw >> 4) & 32'hf;
		if ((raw >> 8) == 32'h55 && (raw & 4) && bd >= 3 && bd <= 8) return raw;
		return 32'h5565;
	endfunction : m_fix

	task check(input string n, input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, x, s);
		end
	endtask : check

	task close_out;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out

	// ------------------------------------------------------------------
	// Bus master tasks: hold each channel until its ready is seen
	// ------------------------------------------------------------------
	task wr(input logic [7:0] a, input logic [31:0] d);
		bit done;
		done = 1'b0;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge clk_sys);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				resp = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : wr

	task rd_reg(input logic [7:0] a);
		bit done;
		done = 1'b0;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge clk_sys);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				rd = rdata;
				resp = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : rd_reg

	// Setting lags the register by one edge
	task settle;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask : settle

	task do_reset(input logic [1:0] s);
		@(posedge clk_sys);
		sw <= s;
		reset_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		reset_n <= 1'b1;
		settle;
	endtask : do_reset

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		do_reset(2'h0);
		for (int i = 0; i < 5; i++) begin
			rd_reg(offs[i]);
			check("reset value", rd, rst[i]);
		end
		rd_reg(8'h14);
		check("status cfg", rd, 32'h111111);
		// Switch moved after capture must be ignored
		for (int s = 0; s < 4; s++) begin
			do_reset(2'(s));
			@(posedge clk_sys);
			sw <= 2'(~s);
			wr(8'h00, 32'h5502);
			settle;
			check("first_serial_port cfg", port_cfg[0], s == 3 ? 32'h11 : 32'h31);
			if (s < 3) check("second_serial_port iface", port_iface[1], s);
			// Captured position stays, the moved pins do not show
			rd_reg(8'h18);
			v = 32'h100 | (s << 6) | ((s % 3) << 2);
			check("status mode", rd, v);
		end
		do_reset(2'h0);
		for (int i = 0; i < 5; i++) begin
			v = (i < 4) ? 32'h5500 + i : $random(seed) & 32'h54ff;
			wr(8'h00, v);
			settle;
			check("first_serial_port cfg", port_cfg[0], m_cfg(0, v));
		end
		// Random keyed and unkeyed values on the second and normal third port
		for (int i = 0; i < 16; i++) begin
			e = (i < 8) ? 1 : 2;
			v = $random(seed) & 32'hffff;
			if (i % 2) v = (v & (e == 1 ? 32'h3f : 32'h7f)) | 32'h5500;
			if (e == 2) pn = v;
			wr(e == 1 ? 8'h04 : 8'h08, v);
			rd_reg(e == 1 ? 8'h04 : 8'h08);
			check("readback", rd, v);
			settle;
			check("port cfg", port_cfg[e], m_cfg(e, v));
		end
		wr(8'h0c, 32'h1234);
		rd_reg(8'h0c);
		check("link idle", rd, 32'h1234);
		wr(8'h10, 32'h2);
		rd_reg(8'h0c);
		check("link repaired", rd, 32'h5565);
		settle;
		check("third_serial_port cfg", port_cfg[2], 32'h65);
		for (int i = 0; i < 5; i++) begin
			wr(8'h0c, lk[i]);
			rd_reg(8'h0c);
			check("link reg", rd, m_fix(lk[i]));
			settle;
			check("third_serial_port cfg", port_cfg[2], m_fix(lk[i]) & 32'hff);
		end
		repeat (20) @(posedge clk_sys);
		check("third_serial_port gap", gap[2], 20000000 / (16 * 614400));
		wr(8'h10, 32'h3);
		settle;
		check("third_serial_port iface", port_iface[2], 2);
		check("third_serial_port std", std_en[2], 0);
		wr(8'h10, 32'h0);
		settle;
		check("third_serial_port iface", port_iface[2], 0);
		check("third_serial_port cfg", port_cfg[2], m_cfg(2, pn));
		wr(8'h1c, 32'hffff);
		check("unmapped wr", resp, spc_pkg::AXI_SLVERR);
		rd_reg(8'h1c);
		check("unmapped rd", rd, 32'h0);
		check("unmapped rresp", resp, spc_pkg::AXI_SLVERR);
		wr(8'h00, 32'h5502);
		repeat (80) @(posedge clk_sys);
		check("first_serial_port gap", gap[0], 20000000 / (16 * 38400));
		close_out;
	end

	// Watchdog: the whole sequence needs well under ten thousand cycles
	initial begin
		repeat (30000) @(posedge clk_sys);
		fail_count++;
		close_out;
	end
endmodule : testbench
